// *** core/dacc_pkg.sv ***
// Summary of operation
// - Bit 21 reads the inverse of the fault output pin level.
// - Bits 20:16 read this register's address; reset word reads 0x110000.
// - Sense buffers for power-control sensing are on only while bit 11 is set.
// - Writing command 100 to bits 10:8 starts one conversion of selected node.
// - Unassigned input-select codes are reserved and convert to zero.
// - Code 00000 main die temperature, 00001 buck die temperature.
// - Code 00011 external reference, valid only while reference enable is set.
// - Code 00100 routes the secondary 1.23 V internal reference.
// - Codes 01101 and 01110 route positive and negative sense buffers.
// - Supplies 10100-10110, grounds 11000-11010, rails 11011-11101, 11111 ref out.
// - Code 11110 routes a buck die node chosen by the second buck settings.
// - Four modes: key sequence, auto sequence, immediate single, single key.
package dacc_pkg;
    localparam int DACC_WORD_W = 22;
    localparam int DACC_ADDR_W = 5;
    localparam logic [4:0] DACC_REG_ADDR = 5'h11;
    localparam logic [21:0] DACC_RESET_WORD = 22'h110000;
    localparam int DACC_FAULT_BIT = 21;
    localparam int DACC_ADDR_HI = 20;
    localparam int DACC_ADDR_LO = 16;
    localparam int DACC_RSV_HI_HI = 15;
    localparam int DACC_RSV_HI_LO = 12;
    localparam int DACC_BUF_BIT = 11;
    localparam int DACC_CMD_HI = 10;
    localparam int DACC_CMD_LO = 8;
    localparam int DACC_RSV_LO_HI = 7;
    localparam int DACC_RSV_LO_LO = 5;
    localparam int DACC_SEL_HI = 4;
    localparam logic [2:0] DACC_CMD_SINGLE = 3'h4;
    localparam logic [2:0] DACC_CMD_IDLE = 3'h0;

    typedef enum logic [4:0]
    {
        DACC_N_MAIN_TEMP = 5'h00,
        DACC_N_BUCK_TEMP = 5'h01,
        DACC_N_EXT_REF = 5'h03,
        DACC_N_SECOND_REF = 5'h04,
        DACC_N_SENSE_POS = 5'h0D,
        DACC_N_SENSE_NEG = 5'h0E,
        DACC_N_ANA_SUPPLY = 5'h14,
        DACC_N_LDO = 5'h15,
        DACC_N_LOGIC = 5'h16,
        DACC_N_REF_GND = 5'h18,
        DACC_N_ANA_GND = 5'h19,
        DACC_N_DIG_GND = 5'h1A,
        DACC_N_PWR_RAIL = 5'h1B,
        DACC_N_AVDD2 = 5'h1C,
        DACC_N_AVSS = 5'h1D,
        DACC_N_BUCK_NODE = 5'h1E,
        DACC_N_REF_OUT = 5'h1F
    } dacc_node_t;

    typedef enum logic [1:0]
    {
        DACC_MODE_KEY_SEQ = 2'h0,
        DACC_MODE_AUTO_SEQ = 2'h1,
        DACC_MODE_IMMEDIATE = 2'h2,
        DACC_MODE_SINGLE_KEY = 2'h3
    } dacc_mode_t;
endpackage

// *** core/dacc_node_decode.sv ***
`timescale 1ns/1ns
module dacc_node_decode
    import dacc_pkg::*;
(
    input wire logic [4:0] sel,
    input wire logic ext_ref_enable,
    output logic [31:0] node_onehot,
    output logic node_valid
);
    // One-hot analog mux steering; reserved codes steer nothing so the result is zero
    always_comb
    begin
        node_onehot = 32'h0;
        node_valid = 1'b1;
        unique case (sel)
            DACC_N_MAIN_TEMP, DACC_N_BUCK_TEMP: ;
            DACC_N_SECOND_REF: ;
            DACC_N_SENSE_POS, DACC_N_SENSE_NEG: ;
            DACC_N_ANA_SUPPLY, DACC_N_LDO, DACC_N_LOGIC, DACC_N_REF_GND, DACC_N_ANA_GND,
            DACC_N_DIG_GND, DACC_N_PWR_RAIL, DACC_N_AVDD2, DACC_N_AVSS, DACC_N_REF_OUT: ;
            DACC_N_BUCK_NODE: ;
            DACC_N_EXT_REF: node_valid = ext_ref_enable;
            default: node_valid = 1'b0;
        endcase
        if (node_valid)
        begin
            node_onehot[sel] = 1'b1;
        end
    end
endmodule

// *** core/dacc_top.sv ***
`timescale 1ns/1ns
module dacc_top
    import dacc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic reg_wr,
    input wire logic [21:0] reg_wdata,
    input wire logic reg_rd,
    output logic [21:0] reg_rdata,
    input wire logic fault_pin,
    input wire logic ext_ref_enable,
    input wire logic [1:0] conv_mode,
    input wire logic conv_busy,
    output logic power_sense_buffer_on,
    output logic [4:0] diag_input_choice,
    output logic [31:0] mux_onehot,
    output logic conv_start,
    output logic [1:0] conv_mode_out,
    output logic zero_result
);
    logic fault_s1_q;
    logic fault_s2_q;
    logic buf_q;
    logic buf_d;
    logic [4:0] sel_q;
    logic [4:0] sel_d;
    logic [2:0] cmd_q;
    logic [2:0] cmd_d;
    logic start_q;
    logic start_d;
    logic [1:0] mode_q;
    logic [1:0] mode_d;
    logic [21:0] rdata_q;
    logic [21:0] rdata_d;
    logic zero_q;
    logic zero_d;
    logic [31:0] onehot;
    logic node_valid;

    dacc_node_decode u_dec
    (
        .sel(sel_q),
        .ext_ref_enable(ext_ref_enable),
        .node_onehot(onehot),
        .node_valid(node_valid)
    );

    // Fault pin is asynchronous to the core
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            // Idle pin level is high, so the status bit reads clear after reset
            fault_s1_q <= 1'b1;
            fault_s2_q <= 1'b1;
        end
        else
        begin
            fault_s1_q <= fault_pin;
            fault_s2_q <= fault_s1_q;
        end
    end

    always_comb
    begin
        buf_d = buf_q;
        sel_d = sel_q;
        cmd_d = cmd_q;
        mode_d = conv_mode;
        start_d = 1'b0;
        zero_d = zero_q;
        if (reg_wr)
        begin
            buf_d = reg_wdata[DACC_BUF_BIT];
            sel_d = reg_wdata[DACC_SEL_HI:0];
            cmd_d = reg_wdata[DACC_CMD_HI:DACC_CMD_LO];
            // Reserved command patterns are stored but start nothing
            if (reg_wdata[DACC_CMD_HI:DACC_CMD_LO] == DACC_CMD_SINGLE)
            begin
                start_d = 1'b1;
                zero_d = 1'b0;
            end
        end
        if (start_q)
        begin
            // Reserved node: conversion result forced to zero
            zero_d = !node_valid;
        end
        rdata_d = rdata_q;
        if (reg_rd)
        begin
            rdata_d = '0;
            rdata_d[DACC_FAULT_BIT] = !fault_s2_q;
            rdata_d[DACC_ADDR_HI:DACC_ADDR_LO] = DACC_REG_ADDR;
            rdata_d[DACC_BUF_BIT] = buf_q;
            rdata_d[DACC_CMD_HI:DACC_CMD_LO] = cmd_q;
            rdata_d[DACC_SEL_HI:0] = sel_q;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            buf_q <= 1'b0;
            sel_q <= 5'h00;
            cmd_q <= DACC_CMD_IDLE;
            start_q <= 1'b0;
            mode_q <= DACC_MODE_KEY_SEQ;
            rdata_q <= DACC_RESET_WORD;
            zero_q <= 1'b0;
        end
        else
        begin
            buf_q <= buf_d;
            sel_q <= sel_d;
            cmd_q <= cmd_d;
            start_q <= start_d;
            mode_q <= mode_d;
            rdata_q <= rdata_d;
            zero_q <= zero_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign power_sense_buffer_on = buf_q;
    assign diag_input_choice = sel_q;
    assign mux_onehot = onehot;
    assign conv_start = start_q;
    assign conv_mode_out = mode_q;
    assign zero_result = zero_q;

    // Command decode and start pulse
    a_single_start: assert property (@(posedge core_clk) disable iff (rst)
        reg_wr && reg_wdata[DACC_CMD_HI:DACC_CMD_LO] == DACC_CMD_SINGLE |=> conv_start)
        else $error("command write did not start a conversion");

    a_one_pulse: assert property (@(posedge core_clk) disable iff (rst)
        conv_start |=> !conv_start
            || $past(reg_wr && reg_wdata[DACC_CMD_HI:DACC_CMD_LO] == DACC_CMD_SINGLE))
        else $error("conversion started without new command");

    // A start with no command behind it would double-convert a node
    a_start_cause: assert property (@(posedge core_clk) disable iff (rst)
        conv_start |-> $past(reg_wr && reg_wdata[DACC_CMD_HI:DACC_CMD_LO] == DACC_CMD_SINGLE))
        else $error("conversion started with no command write");

    a_no_rsv_start: assert property (@(posedge core_clk) disable iff (rst)
        reg_wr && reg_wdata[DACC_CMD_HI:DACC_CMD_LO] != DACC_CMD_SINGLE |=> !conv_start)
        else $error("reserved command started a conversion");

    a_sel_follow: assert property (@(posedge core_clk) disable iff (rst)
        reg_wr |=> diag_input_choice == $past(reg_wdata[DACC_SEL_HI:0]))
        else $error("input choice not taken from write");

    // Register fields
    a_buf_follow: assert property (@(posedge core_clk) disable iff (rst)
        reg_wr |=> power_sense_buffer_on == $past(reg_wdata[DACC_BUF_BIT]))
        else $error("buffer enable not taken from write");

    a_addr_field: assert property (@(posedge core_clk) disable iff (rst)
        $past(reg_rd) |-> reg_rdata[DACC_ADDR_HI:DACC_ADDR_LO] == DACC_REG_ADDR)
        else $error("address field wrong on read");

    a_rdata_hold: assert property (@(posedge core_clk) disable iff (rst)
        !reg_rd |=> $stable(reg_rdata))
        else $error("read word changed without a read");

    a_fault_inv: assert property (@(posedge core_clk) disable iff (rst)
        reg_rd |=> reg_rdata[DACC_FAULT_BIT] == !$past(fault_s2_q))
        else $error("fault status not inverted pin");

    // Conversion result
    a_rsv_zero: assert property (@(posedge core_clk) disable iff (rst)
        conv_start && !node_valid |=> zero_result)
        else $error("reserved node did not yield zero");

    // A start in the same cycle re-evaluates the flag, so it is left out here
    a_zero_clear: assert property (@(posedge core_clk) disable iff (rst)
        reg_wr && reg_wdata[DACC_CMD_HI:DACC_CMD_LO] == DACC_CMD_SINGLE && !conv_start
            |=> !zero_result)
        else $error("zero result not cleared by command");

    a_onehot_clean: assert property (@(posedge core_clk) disable iff (rst)
        $onehot0(mux_onehot))
        else $error("more than one node routed");

    // Multiplexer routing
    a_ext_ref: assert property (@(posedge core_clk) disable iff (rst)
        diag_input_choice == DACC_N_EXT_REF && !ext_ref_enable |-> mux_onehot == 32'h0)
        else $error("external reference routed while disabled");

    a_ext_ref_on: assert property (@(posedge core_clk) disable iff (rst)
        diag_input_choice == DACC_N_EXT_REF && ext_ref_enable |-> mux_onehot == 32'h8)
        else $error("external reference not routed while enabled");

    a_main_temp: assert property (@(posedge core_clk) disable iff (rst)
        diag_input_choice == DACC_N_MAIN_TEMP |-> mux_onehot == 32'h1)
        else $error("main temperature not routed");

    a_buck_temp: assert property (@(posedge core_clk) disable iff (rst)
        diag_input_choice == DACC_N_BUCK_TEMP |-> mux_onehot == 32'h2)
        else $error("buck temperature not routed");

    a_secondary_internal_reference_route: assert property (@(posedge core_clk) disable iff (rst)
        diag_input_choice == DACC_N_SECOND_REF |-> mux_onehot == 32'h10)
        else $error("secondary reference not routed");

    a_sense_pos: assert property (@(posedge core_clk) disable iff (rst)
        diag_input_choice == DACC_N_SENSE_POS |-> mux_onehot == 32'h2000)
        else $error("positive sense buffer not routed");

    a_sense_neg: assert property (@(posedge core_clk) disable iff (rst)
        diag_input_choice == DACC_N_SENSE_NEG |-> mux_onehot == 32'h4000)
        else $error("negative sense buffer not routed");

    a_supply_route: assert property (@(posedge core_clk) disable iff (rst)
        diag_input_choice == DACC_N_ANA_SUPPLY |-> mux_onehot == 32'h100000)
        else $error("internal analog supply not routed");

    a_ground_route: assert property (@(posedge core_clk) disable iff (rst)
        diag_input_choice == DACC_N_REF_GND |-> mux_onehot == 32'h1000000)
        else $error("reference ground not routed");

    a_ref_out: assert property (@(posedge core_clk) disable iff (rst)
        diag_input_choice == DACC_N_REF_OUT |-> mux_onehot == 32'h80000000)
        else $error("reference output not routed");

    a_buck_node: assert property (@(posedge core_clk) disable iff (rst)
        diag_input_choice == DACC_N_BUCK_NODE |-> mux_onehot == 32'h40000000)
        else $error("buck die node not routed");

    // Operating mode
    a_mode_follow: assert property (@(posedge core_clk) disable iff (rst)
        !$past(rst) |-> conv_mode_out == $past(conv_mode))
        else $error("operating mode not passed on");

    c_start: cover property (@(posedge core_clk) conv_start);
    c_zero: cover property (@(posedge core_clk) conv_start ##1 zero_result);
    c_buf: cover property (@(posedge core_clk) power_sense_buffer_on);
    c_ext_ref: cover property (@(posedge core_clk) mux_onehot == 32'h8);
    c_single_key: cover property (@(posedge core_clk)
        conv_start && conv_mode_out == DACC_MODE_SINGLE_KEY);
endmodule

// *** dv/tb_diag_adc_input_select_control.sv ***
`timescale 1ns/1ns
module tb_diag_adc_input_select_control
    import dacc_pkg::*;
;
    // Nodes with an assigned input-select code; all other codes are reserved
    localparam logic [31:0] NODE_MASK = 32'hFF70601B;
    logic core_clk, rst, reg_wr, reg_rd, fault_pin, ext_ref_enable, conv_busy;
    logic [21:0] reg_wdata, reg_rdata;
    logic [1:0] conv_mode, conv_mode_out;
    logic power_sense_buffer_on, conv_start, zero_result;
    logic [4:0] diag_input_choice;
    logic [31:0] mux_onehot;
    int errors, checked;

    dacc_top DUT (.core_clk(core_clk), .rst(rst), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fault_pin(fault_pin),
        .ext_ref_enable(ext_ref_enable), .conv_mode(conv_mode), .conv_busy(conv_busy),
        .power_sense_buffer_on(power_sense_buffer_on), .diag_input_choice(diag_input_choice),
        .mux_onehot(mux_onehot), .conv_start(conv_start), .conv_mode_out(conv_mode_out),
        .zero_result(zero_result));

    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    task conclude();
        $display("Comparisons %0d, mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            $display("ERROR %s expected %h seen %h", name, exp, got);
            errors++;
        end
    endtask

    // Strobe is held for exactly one edge; returns just after the edge that takes it
    task wr(input logic [21:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    task rd(input logic [21:0] exp);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk("reg_rdata", 32'(exp), 32'(reg_rdata));
    endtask

    initial
    begin
        repeat (2000) @(posedge core_clk);
        errors++;
        conclude();
    end

    initial
    begin
        rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 22'h000000;
        fault_pin = 1'b1;
        ext_ref_enable = 1'b1;
        conv_mode = 2'h0;
        conv_busy = 1'b0;
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        rd(DACC_RESET_WORD);
        fault_pin <= 1'b0;
        // Pin is synchronised, so allow a few cycles before looking
        repeat (4) @(posedge core_clk);
        rd(22'h310000);
        wr(22'h000800);
        chk("conv_start", 32'h0, 32'(conv_start));
        rd(22'h310800);
        chk("buffer_on", 32'h1, 32'(power_sense_buffer_on));
        for (int c = 0; c < 32; c++)
        begin
            conv_mode <= c[1:0];
            wr(22'h000400 | 22'(c));
            chk("conv_start", 32'h1, 32'(conv_start));
            chk("choice", 32'(c), 32'(diag_input_choice));
            @(posedge core_clk);
            #1;
            chk("conv_start", 32'h0, 32'(conv_start));
            chk("onehot", NODE_MASK[c] ? 32'h1 << c : 32'h0, mux_onehot);
            chk("zero_result", 32'(!NODE_MASK[c]), 32'(zero_result));
            chk("mode", 32'(c[1:0]), 32'(conv_mode_out));
        end
        chk("buffer_on", 32'h0, 32'(power_sense_buffer_on));
        wr(22'h000403);
        ext_ref_enable <= 1'b0;
        @(posedge core_clk);
        #1;
        chk("onehot", 32'h0, mux_onehot);
        // Reserved command must be stored but never start a conversion
        wr(22'h000504);
        chk("conv_start", 32'h0, 32'(conv_start));
        @(posedge core_clk);
        #1;
        chk("conv_start", 32'h0, 32'(conv_start));
        rd(22'h310504);
        conclude();
    end
endmodule
